// ---- core/mfc_pkg.sv ----
// Constants for the MAC mode register and PAUSE flow-control block.
// Assumes a 20 MHz system clock and a plain strobe register port.
package mfc_pkg;
    localparam logic [7:0]  MODE_ADDR       = 8'h00;
    localparam logic [7:0]  FC_THRESH_ADDR  = 8'h04;
    localparam logic [7:0]  STATUS_ADDR     = 8'h08;
    localparam int          ZERO_TIME_PAUSE_BIT = 19;
    localparam int          PAUSE_FORWARD_BIT   = 18;
    localparam int          RX_FLOW_BIT         = 17;
    localparam int          TX_FLOW_BIT         = 16;
    localparam int          THRESH_MSB          = 7;
    localparam int          STATUS_PAUSED_BIT   = 16;
    localparam int          STATUS_QUANTA_MSB   = 15;
    localparam logic [31:0] READ_IDLE           = 32'h0000_0000;
    localparam logic [15:0] ZERO_QUANTA         = 16'h0000;
    localparam logic [15:0] QUANTA_FINAL        = 16'h0001;
    localparam logic [15:0] QUANTA_STEP         = 16'h0001;
    localparam logic [6:0]  SUB_START           = 7'h00;
    localparam logic [6:0]  SUB_STEP            = 7'h01;
    localparam logic [31:0] MODE_WMASK      = 32'h000F_FFFF;
    localparam logic [31:0] MODE_RESET      = 32'h0000_0000;
    localparam logic [7:0]  THRESH_RESET    = 8'h00;
    // One pause quantum is 512 bit times; at 100 Mb/s that is 5120 ns
    localparam int          QUANTUM_NS      = 5120;
    localparam int          CLK_NS          = 50;
    localparam int          QUANTUM_CYC     = (QUANTUM_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [6:0]  QUANTUM_LAST    = 7'(QUANTUM_CYC - 1);
    typedef enum logic [1:0] {MFC_IDLE, MFC_PAUSED} mfc_state_t;
endpackage : mfc_pkg

// ---- core/mfc_top.sv ----
// MAC mode register with receive/transmit PAUSE flow control.
// Assumes parsed PAUSE frame events and FIFO level arrive on the system clock.
`timescale 1ns/10ps
module mfc_top (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    input  wire logic        PAUSE_RX,
    input  wire logic [15:0] PAUSE_RX_TIME,
    input  wire logic [7:0]  RX_FIFO_LEVEL,
    output logic             PAUSE_FWD,
    output logic             PAUSE_DROP,
    output logic             TX_HOLD,
    output logic             ZERO_PAUSE_REQ,
    output logic             ZERO_TIME_PAUSE_ENABLE,
    output logic             PAUSE_FORWARD_MODE,
    output logic             RECEIVE_FLOW_CONTROL_ENABLE,
    output logic             TRANSMIT_FLOW_CONTROL_ENABLE
);
    // Stored state
    logic [31:0]         mac_operating_mode;
    logic [7:0]          flow_control_fifo_threshold;
    mfc_pkg::mfc_state_t state;
    mfc_pkg::mfc_state_t next_state;
    logic [15:0]         quanta;
    logic [15:0]         next_quanta;
    logic [6:0]          sub;
    logic [6:0]          next_sub;
    logic                below_prev;

    // Decoded mode fields and frame qualifiers
    logic                zero_time_pause_enable;
    logic                pause_forward_mode;
    logic                receive_flow_control_enable;
    logic                transmit_flow_control_enable;
    logic                below;
    logic                zero_frame;
    logic                timed_frame;
    logic                frame_discard;
    logic                quantum_done;
    logic                paused;
    logic [31:0]         status_word;

    // Address match, shared by the write and read decode
    function automatic logic mfc_hit(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction : mfc_hit

    // Zero-timer test, shared by the discard, cancel and reload paths
    function automatic logic mfc_zero_time(input logic [15:0] timer);
        return timer == mfc_pkg::ZERO_QUANTA;
    endfunction : mfc_zero_time

    assign zero_time_pause_enable       = mac_operating_mode[mfc_pkg::ZERO_TIME_PAUSE_BIT];
    assign pause_forward_mode           = mac_operating_mode[mfc_pkg::PAUSE_FORWARD_BIT];
    assign receive_flow_control_enable  = mac_operating_mode[mfc_pkg::RX_FLOW_BIT];
    assign transmit_flow_control_enable = mac_operating_mode[mfc_pkg::TX_FLOW_BIT];

    assign below        = RX_FIFO_LEVEL < flow_control_fifo_threshold;
    assign zero_frame   = PAUSE_RX && mfc_zero_time(PAUSE_RX_TIME);
    assign timed_frame  = PAUSE_RX && !mfc_zero_time(PAUSE_RX_TIME);
    // Zero-timer frames carry no meaning while zero-time control is off
    assign frame_discard = zero_frame && !zero_time_pause_enable;
    assign quantum_done  = sub == mfc_pkg::QUANTUM_LAST;
    assign paused        = state == mfc_pkg::MFC_PAUSED;

    always_comb begin
        status_word                                      = mfc_pkg::READ_IDLE;
        status_word[mfc_pkg::STATUS_PAUSED_BIT]          = paused;
        status_word[mfc_pkg::STATUS_QUANTA_MSB:0]        = quanta;
    end

    // Reserved bits are never stored, so they cannot leak into reads
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mac_operating_mode <= mfc_pkg::MODE_RESET;
        end else if (WR && mfc_hit(ADDR, mfc_pkg::MODE_ADDR)) begin
            mac_operating_mode <= WDATA & mfc_pkg::MODE_WMASK;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            flow_control_fifo_threshold <= mfc_pkg::THRESH_RESET;
        end else if (WR && mfc_hit(ADDR, mfc_pkg::FC_THRESH_ADDR)) begin
            flow_control_fifo_threshold <= WDATA[mfc_pkg::THRESH_MSB:0];
        end
    end

    // Read data stand one cycle after the strobe and are zero otherwise
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= mfc_pkg::READ_IDLE;
        end else if (RD && mfc_hit(ADDR, mfc_pkg::MODE_ADDR)) begin
            RDATA <= mac_operating_mode & mfc_pkg::MODE_WMASK;
        end else if (RD && mfc_hit(ADDR, mfc_pkg::FC_THRESH_ADDR)) begin
            RDATA <= 32'(flow_control_fifo_threshold);
        end else if (RD && mfc_hit(ADDR, mfc_pkg::STATUS_ADDR)) begin
            RDATA <= status_word;
        end else begin
            RDATA <= mfc_pkg::READ_IDLE;
        end
    end

    // Pause timer: a quantum is 512 bit times, rounded up to whole clocks
    always_comb begin
        next_state  = state;
        next_quanta = quanta;
        next_sub    = sub;
        case (state)
            mfc_pkg::MFC_IDLE: begin
                if (receive_flow_control_enable && timed_frame) begin
                    next_state  = mfc_pkg::MFC_PAUSED;
                    next_quanta = PAUSE_RX_TIME;
                    next_sub    = mfc_pkg::SUB_START;
                end
            end
            mfc_pkg::MFC_PAUSED: begin
                if (!receive_flow_control_enable) begin
                    // Turning receive flow control off frees the transmitter at once
                    next_state = mfc_pkg::MFC_IDLE;
                end else if (zero_frame && zero_time_pause_enable) begin
                    next_state  = mfc_pkg::MFC_IDLE;
                    next_quanta = mfc_pkg::ZERO_QUANTA;
                end else if (timed_frame) begin
                    // A fresh frame restarts the wait from its own timer
                    next_quanta = PAUSE_RX_TIME;
                    next_sub    = mfc_pkg::SUB_START;
                end else if (quantum_done) begin
                    next_sub = mfc_pkg::SUB_START;
                    if (quanta == mfc_pkg::QUANTA_FINAL) begin
                        next_state  = mfc_pkg::MFC_IDLE;
                        next_quanta = mfc_pkg::ZERO_QUANTA;
                    end else begin
                        next_quanta = quanta - mfc_pkg::QUANTA_STEP;
                    end
                end else begin
                    next_sub = sub + mfc_pkg::SUB_STEP;
                end
            end
            default: begin
                next_state = mfc_pkg::MFC_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= mfc_pkg::MFC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            quanta <= mfc_pkg::ZERO_QUANTA;
        end else begin
            quanta <= next_quanta;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sub <= mfc_pkg::SUB_START;
        end else begin
            sub <= next_sub;
        end
    end

    // Verdicts are one-cycle pulses, one clock after the frame
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PAUSE_FWD <= 1'b0;
        end else begin
            PAUSE_FWD <= PAUSE_RX && pause_forward_mode && !frame_discard;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PAUSE_DROP <= 1'b0;
        end else begin
            PAUSE_DROP <= PAUSE_RX && (!pause_forward_mode || frame_discard);
        end
    end

    // Hold trails the timer state by a clock; the transmitter samples it
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            TX_HOLD <= 1'b0;
        end else begin
            TX_HOLD <= paused && receive_flow_control_enable;
        end
    end

    // Edge based: a level that stays low asks only once, not every clock
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            below_prev     <= 1'b1;
            ZERO_PAUSE_REQ <= 1'b0;
        end else begin
            below_prev     <= below;
            ZERO_PAUSE_REQ <= transmit_flow_control_enable && zero_time_pause_enable
                              && below && !below_prev;
        end
    end

    // Mode bits exported through flops, one clock behind the register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ZERO_TIME_PAUSE_ENABLE       <= 1'b0;
            PAUSE_FORWARD_MODE           <= 1'b0;
            RECEIVE_FLOW_CONTROL_ENABLE  <= 1'b0;
            TRANSMIT_FLOW_CONTROL_ENABLE <= 1'b0;
        end else begin
            ZERO_TIME_PAUSE_ENABLE       <= zero_time_pause_enable;
            PAUSE_FORWARD_MODE           <= pause_forward_mode;
            RECEIVE_FLOW_CONTROL_ENABLE  <= receive_flow_control_enable;
            TRANSMIT_FLOW_CONTROL_ENABLE <= transmit_flow_control_enable;
        end
    end
endmodule : mfc_top

// ---- sim/mfc_chk.sv ----
// Checker for the mode mirrors and the PAUSE_DROP, TX_HOLD and ZERO_PAUSE_REQ outputs of mfc_top.
// Assumes mode writes and PAUSE events are kept a few cycles apart.
`timescale 1ns/10ps
module mfc_chk (
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic [7:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        PAUSE_RX,
    input wire logic [15:0] PAUSE_RX_TIME,
    input wire logic        PAUSE_DROP,
    input wire logic        TX_HOLD,
    input wire logic        ZERO_PAUSE_REQ,
    input wire logic        ZERO_TIME_PAUSE_ENABLE,
    input wire logic        PAUSE_FORWARD_MODE,
    input wire logic        RECEIVE_FLOW_CONTROL_ENABLE,
    input wire logic        TRANSMIT_FLOW_CONTROL_ENABLE
);
    logic [3:0] wbits;
    assign wbits = {WDATA[mfc_pkg::ZERO_TIME_PAUSE_BIT], WDATA[mfc_pkg::PAUSE_FORWARD_BIT],
                    WDATA[mfc_pkg::RX_FLOW_BIT], WDATA[mfc_pkg::TX_FLOW_BIT]};
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence nz_pause;
        PAUSE_RX && PAUSE_RX_TIME != 16'h0000 && RECEIVE_FLOW_CONTROL_ENABLE;
    endsequence
    sequence z_pause;
        PAUSE_RX && PAUSE_RX_TIME == 16'h0000;
    endsequence
    mode_mirror_a: assert property (WR && ADDR == mfc_pkg::MODE_ADDR |-> ##2
        {ZERO_TIME_PAUSE_ENABLE, PAUSE_FORWARD_MODE, RECEIVE_FLOW_CONTROL_ENABLE,
         TRANSMIT_FLOW_CONTROL_ENABLE} == $past(wbits, 2))
        else $error("mode mirror differs from written value");
    zero_drop_a: assert property (z_pause ##0 !ZERO_TIME_PAUSE_ENABLE |=> PAUSE_DROP)
        else $error("zero-timer pause not dropped");
    hold_keep_a: assert property (z_pause ##0 (!ZERO_TIME_PAUSE_ENABLE && TX_HOLD) |=> ##1 TX_HOLD)
        else $error("ignored zero pause ended the hold");
    hold_start_a: assert property (nz_pause |=> ##1 TX_HOLD)
        else $error("hold missing two cycles after pause");
    hold_cause_a: assert property ($rose(TX_HOLD) |-> $past(PAUSE_RX, 2))
        else $error("hold rose without a pause");
    zero_cancel_a: assert property (z_pause ##0 (ZERO_TIME_PAUSE_ENABLE && RECEIVE_FLOW_CONTROL_ENABLE)
        |=> ##1 !TX_HOLD)
        else $error("zero pause did not end the hold");
    no_detect_a: assert property (!RECEIVE_FLOW_CONTROL_ENABLE [*3] |-> !TX_HOLD)
        else $error("hold while receive flow control off");
    zero_req_a: assert property (ZERO_PAUSE_REQ |-> ZERO_TIME_PAUSE_ENABLE && TRANSMIT_FLOW_CONTROL_ENABLE)
        else $error("zero pause request while disabled");
endmodule : mfc_chk
bind mfc_top mfc_chk chk_i (.*);

// ---- sim/testbench.sv ----
// Directed bench for the mode register and PAUSE flow control.
// Assumes a 50 ns clock; timing checks also run in the bound checker.
`timescale 1ns/10ps
module testbench;
    logic        CLK, RST_N, WR, RD, PAUSE_RX, FWD, DROP, HOLD, ZREQ;
    logic [7:0]  ADDR, LVL;
    logic [31:0] WDATA, RDATA;
    logic [15:0] PTIME;
    int          err_total = 0, tests_run = 0, n, hold_cyc;
    mfc_top dut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .PAUSE_RX(PAUSE_RX), .PAUSE_RX_TIME(PTIME), .RX_FIFO_LEVEL(LVL),
        .PAUSE_FWD(FWD), .PAUSE_DROP(DROP), .TX_HOLD(HOLD), .ZERO_PAUSE_REQ(ZREQ),
        .ZERO_TIME_PAUSE_ENABLE(), .PAUSE_FORWARD_MODE(), .RECEIVE_FLOW_CONTROL_ENABLE(),
        .TRANSMIT_FLOW_CONTROL_ENABLE());
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    always @(posedge CLK) if (HOLD === 1'b1) hold_cyc <= hold_cyc + 1;
    task summarize;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        {ADDR, WDATA, WR} <= {a, d, 1'b1};
        @(posedge CLK);
        WR <= 1'b0;
        // Mirrors trail the register by a cycle
        repeat (3) @(posedge CLK);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge CLK);
        {ADDR, RD} <= {a, 1'b1};
        @(posedge CLK);
        RD <= 1'b0;
        #1 chk(RDATA, exp);
    endtask : rd
    task pz(input logic [15:0] t, input logic fwd);
        @(posedge CLK);
        {PTIME, PAUSE_RX} <= {t, 1'b1};
        @(posedge CLK);
        PAUSE_RX <= 1'b0;
        #1 chk(32'({FWD, DROP}), 32'({fwd, ~fwd}));
    endtask : pz
    task wt(input logic z, input logic v, input int lim);
        for (n = 0; (z ? ZREQ : HOLD) !== v; n++) begin
            if (n == lim) begin
                err_total++;
                summarize();
            end
            @(posedge CLK);
            #1;
        end
        tests_run++;
    endtask : wt
    initial begin
        {RST_N, WR, RD, PAUSE_RX, ADDR, WDATA, PTIME, LVL} = '0;
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        rd(8'h00, 32'h0000_0000);
        wr(8'h00, 32'h000F_0000);
        rd(8'h00, 32'h000F_0000);
        rd(8'h0C, 32'h0000_0000);
        $display("test registers done");
        wr(8'h00, 32'h0002_0000);
        hold_cyc = 0;
        pz(16'h0002, 1'b0);
        wt(1'b0, 1'b1, 3);
        pz(16'h0000, 1'b0);
        wt(1'b0, 1'b0, 300);
        chk(hold_cyc, 32'(2 * mfc_pkg::QUANTUM_CYC));
        $display("test pause timing done");
        wr(8'h00, 32'h000E_0000);
        pz(16'h0005, 1'b1);
        wt(1'b0, 1'b1, 3);
        rd(8'h08, 32'h0001_0005);
        pz(16'h0000, 1'b1);
        wt(1'b0, 1'b0, 2);
        wr(8'h00, 32'h0000_0000);
        pz(16'h0005, 1'b0);
        repeat (3) @(posedge CLK);
        chk(32'(HOLD), 32'h0000_0000);
        $display("test zero pause done");
        wr(8'h04, 32'h0000_0010);
        rd(8'h04, 32'h0000_0010);
        @(posedge CLK) LVL <= 8'h20;
        wr(8'h00, 32'h0009_0000);
        @(posedge CLK) LVL <= 8'h08;
        wt(1'b1, 1'b1, 4);
        $display("test zero request done");
        summarize();
    end
endmodule : testbench
